// *** core/rbseq_pkg.sv ***
// Purpose: constants for the reset and start-up sequencer
// Assumes: core clock stands in for the input clock pin
// Notes: quarter-clock unit is two input clock periods
package rbseq_pkg;
   localparam int unsigned CLK_DIV = 8;
   localparam int unsigned QTR_DIV = 2;
   localparam int unsigned PH_W = 3;
   localparam logic [2:0] PH1_RISE = 3'h0;
   localparam logic [2:0] PH1_FALL = 3'h4;
   localparam logic [2:0] PH2_RISE = 3'h2;
   localparam logic [2:0] PH2_FALL = 3'h6;
   localparam logic [2:0] PH_LAST = 3'h7;
   localparam int unsigned IGNORE_PERIODS = 17;
   localparam int unsigned REFRESH_CYCLES = 8;
   localparam int unsigned CNT_W = 5;
   localparam logic [4:0] CNT_ZERO = 5'h00;
   localparam logic [4:0] CNT_ONE = 5'h01;
   typedef enum logic [1:0] {
      RBSEQ_RESET = 2'b00,
      RBSEQ_IGNORE = 2'b01,
      RBSEQ_REFRESH = 2'b10,
      RBSEQ_RUN = 2'b11
   } rbseq_state_t;
endpackage

// *** core/rbseq_sync.sv ***
// Purpose: two-flop synchroniser for an asynchronous level
// Assumes: single core clock, clock enable freezes it
// Notes: reset value is a parameter constant
`timescale 1ns/100ps
module rbseq_sync #(
   parameter logic INIT = 1'b1
) (
   // clock and reset
   input wire logic core_clk_in,
   input wire logic rst_n_in,
   input wire logic clk_en_in,
   // level
   input wire logic async_in,
   output logic sync_out
);
   logic meta_r;
   logic sync_r;
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         meta_r <= INIT;
         sync_r <= INIT;
      end else if (clk_en_in) begin
         meta_r <= async_in;
         sync_r <= meta_r;
      end
   end
   assign sync_out = sync_r;
endmodule

// *** core/rbseq_top.sv ***
// Purpose: reset bootstrap sequencer, local clocks and host select gating
// Assumes: core_clk_in is the input clock; pin levels are asynchronous
// Notes: halt control bit released by host_release_in pulse
//
// Notes on behaviour
// - local clock phases are input clock divided by eight
// - only the frequency ratio is guaranteed, not alignment
// - quarter-clock unit equals two input clocks
// - reset and select pass through synchronising latches
// - sample synchronised inputs at phase one falling edge
// - select low at reset end clears halt bit
// - ignore select seventeen local periods after reset rise
// - eight refresh cycles follow reset end
// - after refresh, low select means host access
`timescale 1ns/100ps
module rbseq_top
   import rbseq_pkg::*;
#(
   parameter int unsigned IGNORE_N = rbseq_pkg::IGNORE_PERIODS,
   parameter int unsigned REFRESH_N = rbseq_pkg::REFRESH_CYCLES
) (
   // clock and reset
   input wire logic core_clk_in,
   input wire logic rst_n_in,
   input wire logic clk_en_in,
   // external pins
   input wire logic reset_n_pin_in,
   input wire logic host_select_n_in,
   input wire logic host_release_in,
   // local clocks
   output logic local_clock_phase_one_out,
   output logic local_clock_phase_two_out,
   output logic quarter_tick_out,
   // sequencing status
   output logic device_in_reset_out,
   output logic halt_control_bit_out,
   output logic refresh_strobe_out,
   output logic refreshing_out,
   output logic host_access_sel_out
);
   import rbseq_pkg::*;

   // ****************************************
   // state
   // ****************************************
   typedef struct packed {
      logic [PH_W-1:0] div;
      rbseq_state_t st;
      logic [CNT_W-1:0] cnt;
      logic ph1;
      logic ph2;
      logic rst_smp;
      logic sel_smp;
      logic halt;
      logic ref_stb;
      logic sel;
   } rbseq_regs_t;

   rbseq_regs_t q_r;
   rbseq_regs_t q_nxt;
   logic reset_n_sync;
   logic select_n_sync;
   logic ph1_fall_edge;

   // ****************************************
   // input synchronisers
   // ****************************************
   // both pins are asynchronous, so two flops each before use
   rbseq_sync #(.INIT(1'b0)) u_sync_rst (
      .core_clk_in(core_clk_in),
      .rst_n_in(rst_n_in),
      .clk_en_in(clk_en_in),
      .async_in(reset_n_pin_in),
      .sync_out(reset_n_sync)
   );
   rbseq_sync #(.INIT(1'b1)) u_sync_sel (
      .core_clk_in(core_clk_in),
      .rst_n_in(rst_n_in),
      .clk_en_in(clk_en_in),
      .async_in(host_select_n_in),
      .sync_out(select_n_sync)
   );

   // ****************************************
   // divider and sequencer
   // ****************************************
   function automatic logic at_phase(input logic [PH_W-1:0] d, input logic [PH_W-1:0] p);
      return d == p;
   endfunction

   assign ph1_fall_edge = at_phase(q_r.div, PH1_FALL);

   always_comb begin
      q_nxt = q_r;
      q_nxt.ref_stb = 1'b0;
      // free-running divide by eight; no phase lock to the input edge
      q_nxt.div = (q_r.div == PH_LAST) ? '0 : q_r.div + 1'b1;
      if (at_phase(q_r.div, PH1_RISE)) begin
         q_nxt.ph1 = 1'b1;
      end else if (at_phase(q_r.div, PH1_FALL)) begin
         q_nxt.ph1 = 1'b0;
      end
      // phase two lags phase one by one quarter unit
      if (at_phase(q_r.div, PH2_RISE)) begin
         q_nxt.ph2 = 1'b1;
      end else if (at_phase(q_r.div, PH2_FALL)) begin
         q_nxt.ph2 = 1'b0;
      end
      if (ph1_fall_edge) begin
         q_nxt.rst_smp = reset_n_sync;
         q_nxt.sel_smp = select_n_sync;
         q_nxt.sel = 1'b0;
         unique case (q_r.st)
            RBSEQ_RESET: begin
               if (reset_n_sync) begin
                  // select level at the reset-rise edge picks start mode
                  q_nxt.halt = select_n_sync;
                  q_nxt.st = RBSEQ_IGNORE;
                  q_nxt.cnt = CNT_W'(IGNORE_N - 1);
               end
            end
            RBSEQ_IGNORE: begin
               if (q_r.cnt == CNT_ZERO) begin
                  q_nxt.st = RBSEQ_REFRESH;
                  q_nxt.cnt = CNT_W'(REFRESH_N);
               end else begin
                  q_nxt.cnt = q_r.cnt - CNT_ONE;
               end
            end
            RBSEQ_REFRESH: begin
               q_nxt.ref_stb = 1'b1;
               q_nxt.cnt = q_r.cnt - CNT_ONE;
               if (q_r.cnt == CNT_ONE) begin
                  q_nxt.st = RBSEQ_RUN;
               end
            end
            RBSEQ_RUN: begin
               q_nxt.sel = ~select_n_sync;
            end
         endcase
      end
      if (host_release_in && q_r.st != RBSEQ_RESET) begin
         q_nxt.halt = 1'b0;
      end
      // reset low seen at a sample edge restarts the sequencer state, halt, select and count; the divider keeps running
      if (ph1_fall_edge && !reset_n_sync) begin
         q_nxt.st = RBSEQ_RESET;
         q_nxt.halt = 1'b1;
         q_nxt.sel = 1'b0;
         q_nxt.cnt = CNT_ZERO;
      end
   end

   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         q_r <= '{div: '0, st: RBSEQ_RESET, cnt: '0, ph1: 1'b0, ph2: 1'b0,
                  rst_smp: 1'b0, sel_smp: 1'b1, halt: 1'b1, ref_stb: 1'b0, sel: 1'b0};
      end else if (clk_en_in) begin
         q_r <= q_nxt;
      end
   end

   assign local_clock_phase_one_out = q_r.ph1;
   assign local_clock_phase_two_out = q_r.ph2;
   assign quarter_tick_out = q_r.div[0];
   assign device_in_reset_out = (q_r.st == RBSEQ_RESET);
   assign halt_control_bit_out = q_r.halt;
   assign refresh_strobe_out = q_r.ref_stb;
   assign refreshing_out = (q_r.st == RBSEQ_REFRESH);
   assign host_access_sel_out = q_r.sel;

   // ****************************************
   // checks
   // ****************************************
   property p_ph1_period;
      @(posedge core_clk_in) disable iff (!rst_n_in)
      // eight enabled edges after a rise must bring the next rise
      $rose(q_r.ph1) ##0 clk_en_in [*8] |=> $rose(q_r.ph1);
   endproperty
   a_ph1_period: assert property (p_ph1_period) else $error("phase one period wrong");

   property p_ph2_lag;
      @(posedge core_clk_in) disable iff (!rst_n_in)
      // enable must be high on both updating edges, else the lag stretches
      $rose(q_r.ph1) && clk_en_in ##1 clk_en_in |=> $rose(q_r.ph2);
   endproperty
   a_ph2_lag: assert property (p_ph2_lag) else $error("phase two not one quarter late");

   property p_no_sel_early;
      @(posedge core_clk_in) disable iff (!rst_n_in)
      (q_r.st != RBSEQ_RUN) |-> !host_access_sel_out;
   endproperty
   a_no_sel_early: assert property (p_no_sel_early) else $error("select honoured too early");

   property p_refresh_count;
      @(posedge core_clk_in) disable iff (!rst_n_in)
      (q_r.st == RBSEQ_REFRESH && q_r.cnt == CNT_ONE && ph1_fall_edge && clk_en_in
       && reset_n_sync) |=> (q_r.st == RBSEQ_RUN) && refresh_strobe_out;
   endproperty
   a_refresh_count: assert property (p_refresh_count) else $error("refresh end wrong");

   property p_boot_mode;
      @(posedge core_clk_in) disable iff (!rst_n_in)
      (q_r.st == RBSEQ_RESET && ph1_fall_edge && clk_en_in && reset_n_sync)
      |=> (halt_control_bit_out == $past(select_n_sync));
   endproperty
   a_boot_mode: assert property (p_boot_mode) else $error("start mode mismatch");

   property p_reset_halts;
      @(posedge core_clk_in) disable iff (!rst_n_in)
      (ph1_fall_edge && clk_en_in && !reset_n_sync) |=> halt_control_bit_out && device_in_reset_out;
   endproperty
   a_reset_halts: assert property (p_reset_halts) else $error("reset did not halt");

   property p_sample_edge;
      @(posedge core_clk_in) disable iff (!rst_n_in)
      (clk_en_in && !ph1_fall_edge) |=> $stable(q_r.rst_smp);
   endproperty
   a_sample_edge: assert property (p_sample_edge) else $error("sampled off edge");

   property p_sel_follows;
      @(posedge core_clk_in) disable iff (!rst_n_in)
      (q_r.st == RBSEQ_RUN && ph1_fall_edge && clk_en_in && reset_n_sync)
      |=> host_access_sel_out == !$past(select_n_sync);
   endproperty
   a_sel_follows: assert property (p_sel_follows) else $error("select not followed");

   c_self_boot: cover property (@(posedge core_clk_in) $fell(halt_control_bit_out));
   c_refresh: cover property (@(posedge core_clk_in) $rose(refreshing_out));
   c_run_sel: cover property (@(posedge core_clk_in) $rose(host_access_sel_out));
endmodule

// *** dv/rbseq_host_model.sv ***
// Purpose: host side model driving the reset and select pins
// Assumes: pins change 1 ns after a core clock edge
// Notes: both pins are always driven, so no released level exists
`timescale 1ns/100ps
module rbseq_host_model (
   // clock
   input wire logic core_clk_in,
   // pins
   output logic reset_n_pin_out,
   output logic host_select_n_out
);
   initial begin
      reset_n_pin_out = 1'b1;
      host_select_n_out = 1'b1;
   end
   // reset pulse, select low from the start for bootstrap
   task automatic boot(input logic self_boot, input int low_clks);
      @(posedge core_clk_in);
      #1 reset_n_pin_out = 1'b0;
      host_select_n_out = ~self_boot;
      repeat (low_clks) @(posedge core_clk_in);
      #1 reset_n_pin_out = 1'b1;
   endtask
   // delayed select change, slow or prompt
   task automatic select(input int dly, input logic lvl_n);
      repeat (dly) @(posedge core_clk_in);
      #1 host_select_n_out = lvl_n;
   endtask
endmodule

// *** dv/tb_reset_bootstrap_sequencer.sv ***
// Purpose: self-checking bench for the reset bootstrap sequencer
// Assumes: default ignore and refresh counts
// Notes: ignore span judged within one local period of slack
`timescale 1ns/100ps
module tb_reset_bootstrap_sequencer;
   import rbseq_pkg::*;
   logic core_clk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic clk_en_in = 1'b1;
   logic host_release_in = 1'b0;
   logic rst_pin, sel_n, ph1, ph2, qtick, in_rst, halt, rstrobe, refreshing, hsel;
   int fails = 0;
   int total_checks = 0;
   rbseq_host_model u_host (.core_clk_in(core_clk_in), .reset_n_pin_out(rst_pin),
      .host_select_n_out(sel_n));
   rbseq_top u_dut (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .clk_en_in(clk_en_in),
      .reset_n_pin_in(rst_pin), .host_select_n_in(sel_n), .host_release_in(host_release_in),
      .local_clock_phase_one_out(ph1), .local_clock_phase_two_out(ph2),
      .quarter_tick_out(qtick), .device_in_reset_out(in_rst), .halt_control_bit_out(halt),
      .refresh_strobe_out(rstrobe), .refreshing_out(refreshing), .host_access_sel_out(hsel));
   initial forever #4 core_clk_in = ~core_clk_in;
   // ********
   // helpers
   // ********
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("mismatch %s expected %0h seen %0h", what, exp, got);
      end
   endtask
   // bounded wait; level still not seen when the limit is reached is a mismatch
   task automatic wait_lvl(ref logic sig, input logic lvl, input int lim, output int n);
      n = 0;
      while (sig !== lvl && n < lim) begin
         @(posedge core_clk_in);
         #1 n++;
      end
      check("wait level", lvl, sig);
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // ********
   // tests
   // ********
   task automatic t_clocks();
      int n;
      logic q;
      wait_lvl(ph1, 1'b0, 16, n);
      wait_lvl(ph1, 1'b1, 16, n);
      wait_lvl(ph2, 1'b1, 16, n);
      check("phase two lag", 2, n);
      wait_lvl(ph1, 1'b0, 16, n);
      check("phase one high rest", 2, n);
      wait_lvl(ph1, 1'b1, 16, n);
      check("phase one low", 4, n);
      q = qtick;
      @(posedge core_clk_in);
      #1 check("quarter tick", !q, qtick);
      clk_en_in = 1'b0;
      q = ph1;
      repeat (5) @(posedge core_clk_in);
      #1 check("frozen phase", q, ph1);
      clk_en_in = 1'b1;
      $display("test clocks done");
   endtask
   task automatic t_boot(input logic self_boot);
      int n, m, k;
      u_host.boot(self_boot, 330);
      check("in reset", 1, in_rst);
      fork
         u_host.select(24, 1'b1);
      join_none
      wait_lvl(in_rst, 1'b0, 24, n);
      k = 0;
      m = 0;
      while (rstrobe !== 1'b1 && m < 200) begin
         if (hsel !== 1'b0) k++;
         @(posedge core_clk_in);
         #1 m++;
      end
      check("select ignored", 0, k);
      check("ignore span", 1, m >= 136 && m <= 152);
      check("refreshing", 1, refreshing);
      check("halt bit", !self_boot, halt);
      k = 0;
      repeat (80) begin
         k += rstrobe;
         @(posedge core_clk_in);
         #1;
      end
      check("refresh count", REFRESH_CYCLES, k);
      check("refresh over", 0, refreshing);
      u_host.select(1, 1'b0);
      wait_lvl(hsel, 1'b1, 24, n);
      u_host.select(1, 1'b1);
      wait_lvl(hsel, 1'b0, 24, n);
      if (!self_boot) begin
         check("halt held", 1, halt);
         host_release_in = 1'b1;
         repeat (8) @(posedge core_clk_in);
         #1 host_release_in = 1'b0;
         wait_lvl(halt, 1'b0, 12, n);
      end
      $display("test boot %0d done", self_boot);
   endtask
   // stuck sequencer guard, tests need about 1200 cycles
   initial begin
      repeat (5000) @(posedge core_clk_in);
      fails++;
      conclude();
   end
   initial begin
      repeat (5) @(posedge core_clk_in);
      #1 rst_n_in = 1'b1;
      t_clocks();
      t_boot(1'b1);
      t_boot(1'b0);
      conclude();
   end
endmodule
